//--- design/unsigned_simd_add_unit.sv
// What this block does
// RULE_01 - Wrapping byte lanes keep sum modulo 256
// RULE_02 - Saturating byte lanes clamp overflow to 0xFF
// RULE_03 - Any lane overflow sets control bit 20
// RULE_04 - Overflow is carry of one-bit-widened sum
// RULE_05 - Wrapping halfword lanes keep sum modulo 65536
// RULE_06 - Saturating halfword lanes clamp to 0xFFFF
// RULE_07 - Eight-byte forms use all eight lanes
// RULE_08 - Four-halfword forms fill all 64 bits
// RULE_09 - Two-halfword forms fill upper with bit 31
// RULE_10 - Four-byte forms fill upper with bit 31
// RULE_11 - No exception ever depends on operand values
// RULE_12 - Reserved and disabled faults replace completion
// RULE_13 - Major opcode and register fields fixed
// RULE_14 - Two-halfword function and sub-operation codes
// RULE_15 - Four-byte function and sub-operation codes
// RULE_16 - Four-halfword function and sub-operation codes
// RULE_17 - Eight-byte function and sub-operation codes
// RULE_18 - Overflow bit sticky, other bits untouched
module unsigned_simd_add_unit
    import simd_add_pkg::*;
#(
    parameter int unsigned DATA_WIDTH = 64
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    // Issue from pipeline
    input  wire issue_type             issue,
    // Control state write from software path
    input  wire logic                  ctrl_write,
    input  wire logic [CTRL_WIDTH-1:0] ctrl_write_data,
    // Retire to register file
    output retire_type                 retire,
    // Control state
    output logic      [CTRL_WIDTH-1:0] dsp_control_state
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (DATA_WIDTH != 64) begin : g_width_check
        $error("unsigned_simd_add_unit: DATA_WIDTH must be 64");
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [5:0] opcode;
    logic [5:0] func;
    logic [4:0] subop;
    add_op_type op;
    logic       saturate;

    assign opcode = issue.instruction[OPCODE_HI:OPCODE_LO];   // RULE_13
    assign func   = issue.instruction[FUNC_HI:FUNC_LO];
    assign subop  = issue.instruction[SUBOP_HI:SUBOP_LO];

    always_comb begin
        op = op_none;
        if (opcode == EXTENSION_MAJOR_OPCODE) begin   // RULE_13
            if (func == FUNC_NARROW) begin
                case (subop)
                    SUBOP_HALF_WRAP: op = wrap_add_two_halfwords;   // RULE_14
                    SUBOP_HALF_SAT:  op = sat_add_two_halfwords;    // RULE_14
                    SUBOP_BYTE_WRAP: op = wrap_add_four_bytes;      // RULE_15
                    SUBOP_BYTE_SAT:  op = sat_add_four_bytes;       // RULE_15
                    default:         op = op_none;
                endcase
            end else if (func == FUNC_WIDE) begin
                case (subop)
                    SUBOP_HALF_WRAP: op = wrap_add_four_halfwords;  // RULE_16
                    SUBOP_HALF_SAT:  op = sat_add_four_halfwords;   // RULE_16
                    SUBOP_BYTE_WRAP: op = wrap_add_eight_bytes;     // RULE_17
                    SUBOP_BYTE_SAT:  op = sat_add_eight_bytes;      // RULE_17
                    default:         op = op_none;
                endcase
            end
        end
    end

    always_comb begin
        case (op)
            sat_add_eight_bytes,
            sat_add_four_bytes,
            sat_add_two_halfwords,
            sat_add_four_halfwords: saturate = 1'b1;
            default:                saturate = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Lane adders
    // ------------------------------------------------------------
    logic [63:0] byte_sum;
    logic [7:0]  byte_ovf;
    logic [63:0] half_sum;
    logic [3:0]  half_ovf;

    for (genvar i = 0; i < 8; i++) begin : g_byte
        lane_adder #(
            .WIDTH (8)
        ) u_byte (
            .lane_a        (issue.source_a[8*i +: 8]),   // RULE_07
            .lane_b        (issue.source_b[8*i +: 8]),
            .saturate      (saturate),                   // RULE_01
            .lane_sum      (byte_sum[8*i +: 8]),         // RULE_02
            .lane_overflow (byte_ovf[i])
        );
    end

    for (genvar j = 0; j < 4; j++) begin : g_half
        lane_adder #(
            .WIDTH (16)
        ) u_half (
            .lane_a        (issue.source_a[16*j +: 16]),
            .lane_b        (issue.source_b[16*j +: 16]),
            .saturate      (saturate),                   // RULE_05
            .lane_sum      (half_sum[16*j +: 16]),       // RULE_06
            .lane_overflow (half_ovf[j])
        );
    end

    // ------------------------------------------------------------
    // Result assembly
    // ------------------------------------------------------------
    logic [63:0] result;
    logic        any_overflow;

    always_comb begin
        case (op)
            wrap_add_eight_bytes,
            sat_add_eight_bytes:    result = byte_sum;                        // RULE_07
            wrap_add_four_halfwords,
            sat_add_four_halfwords: result = half_sum;                        // RULE_08
            wrap_add_two_halfwords,
            sat_add_two_halfwords:  result = {{32{half_sum[31]}}, half_sum[31:0]}; // RULE_09
            wrap_add_four_bytes,
            sat_add_four_bytes:     result = {{32{byte_sum[31]}}, byte_sum[31:0]}; // RULE_10
            default:                result = 64'h0000_0000_0000_0000;
        endcase
    end

    always_comb begin
        case (op)
            wrap_add_eight_bytes,
            sat_add_eight_bytes:    any_overflow = |byte_ovf;                // RULE_03
            wrap_add_four_bytes,
            sat_add_four_bytes:     any_overflow = |byte_ovf[3:0];           // RULE_03
            wrap_add_four_halfwords,
            sat_add_four_halfwords: any_overflow = |half_ovf;                // RULE_03
            wrap_add_two_halfwords,
            sat_add_two_halfwords:  any_overflow = |half_ovf[1:0];           // RULE_03
            default:                any_overflow = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Faults
    // ------------------------------------------------------------
    logic reserved_fault;
    logic disabled_fault;
    logic completes;

    // Only the encoding and the enable matter, never operand values
    assign reserved_fault = issue.valid && (op == op_none);              // RULE_12
    assign disabled_fault = issue.valid && !reserved_fault
                            && !issue.extension_enabled;                 // RULE_12
    assign completes      = issue.valid && !reserved_fault
                            && !disabled_fault;                          // RULE_11

    // ------------------------------------------------------------
    // Retire register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            retire <= '0;
        end else begin
            retire.valid          <= issue.valid;
            retire.dest           <= issue.instruction[DEST_HI:DEST_LO];   // RULE_13
            retire.data           <= completes ? result : 64'h0000_0000_0000_0000;
            retire.reserved_fault <= reserved_fault;                       // RULE_12
            retire.disabled_fault <= disabled_fault;                       // RULE_12
        end
    end

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    logic [CTRL_WIDTH-1:0] ctrl_d;

    always_comb begin
        ctrl_d = ctrl_write ? ctrl_write_data : dsp_control_state;
        // Set wins over a software write in the same cycle
        if (completes && any_overflow) begin
            ctrl_d[OVERFLOW_BIT] = 1'b1;   // RULE_18
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dsp_control_state <= CTRL_RESET;
        end else begin
            dsp_control_state <= ctrl_d;   // RULE_03
        end
    end

endmodule : unsigned_simd_add_unit

//--- design/simd_add_pkg.sv
package simd_add_pkg;

    // ------------------------------------------------------------
    // Instruction fields
    // ------------------------------------------------------------
    localparam int unsigned OPCODE_HI            = 31;
    localparam int unsigned OPCODE_LO            = 26;
    localparam int unsigned SRC_A_HI             = 25;
    localparam int unsigned SRC_A_LO             = 21;
    localparam int unsigned SRC_B_HI             = 20;
    localparam int unsigned SRC_B_LO             = 16;
    localparam int unsigned DEST_HI              = 15;
    localparam int unsigned DEST_LO              = 11;
    localparam int unsigned SUBOP_HI             = 10;
    localparam int unsigned SUBOP_LO             = 6;
    localparam int unsigned FUNC_HI              = 5;
    localparam int unsigned FUNC_LO              = 0;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [5:0] EXTENSION_MAJOR_OPCODE = 6'h1F;
    localparam logic [5:0] FUNC_NARROW            = 6'h10;
    localparam logic [5:0] FUNC_WIDE              = 6'h14;
    localparam logic [4:0] SUBOP_BYTE_WRAP        = 5'h00;
    localparam logic [4:0] SUBOP_BYTE_SAT         = 5'h04;
    localparam logic [4:0] SUBOP_HALF_WRAP        = 5'h08;
    localparam logic [4:0] SUBOP_HALF_SAT         = 5'h0C;

    // ------------------------------------------------------------
    // Control state layout
    // ------------------------------------------------------------
    localparam int unsigned CTRL_WIDTH           = 32;
    localparam int unsigned OVERFLOW_BIT         = 20;
    localparam logic [31:0] CTRL_RESET           = 32'h0000_0000;

    typedef enum logic [3:0] {
        op_none,
        wrap_add_eight_bytes,
        sat_add_eight_bytes,
        wrap_add_two_halfwords,
        sat_add_two_halfwords,
        wrap_add_four_bytes,
        sat_add_four_bytes,
        wrap_add_four_halfwords,
        sat_add_four_halfwords
    } add_op_type;

    typedef struct packed {
        logic        valid;
        logic [31:0] instruction;
        logic [63:0] source_a;
        logic [63:0] source_b;
        logic        extension_enabled;
    } issue_type;

    typedef struct packed {
        logic        valid;
        logic [4:0]  dest;
        logic [63:0] data;
        logic        reserved_fault;
        logic        disabled_fault;
    } retire_type;

endpackage : simd_add_pkg

//--- design/lane_adder.sv
module lane_adder #(
    parameter int unsigned WIDTH = 8
) (
    // Operands
    input  wire logic [WIDTH-1:0] lane_a,
    input  wire logic [WIDTH-1:0] lane_b,
    input  wire logic             saturate,
    // Result
    output logic      [WIDTH-1:0] lane_sum,
    output logic                  lane_overflow
);

    logic [WIDTH:0] wide_sum;

    if (WIDTH < 1) begin : g_width_check
        $error("lane_adder: WIDTH must be at least 1");
    end

    // Widen by one zero bit and look at the carry
    assign wide_sum      = {1'b0, lane_a} + {1'b0, lane_b};   // RULE_04
    assign lane_overflow = wide_sum[WIDTH];                    // RULE_04
    assign lane_sum      = (saturate && lane_overflow) ? {WIDTH{1'b1}}
                                                       : wide_sum[WIDTH-1:0];

endmodule : lane_adder

//--- tb/simd_add_asserts.sv
module simd_add_asserts
    import simd_add_pkg::*;
(
    // Clock and reset
    input wire logic                  clock,
    input wire logic                  rst_n,
    // Inputs
    input wire issue_type             issue,
    input wire logic                  ctrl_write,
    input wire logic [CTRL_WIDTH-1:0] ctrl_write_data,
    // Outputs
    input wire retire_type            retire,
    input wire logic [CTRL_WIDTH-1:0] dsp_control_state
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // Decode
    // ----
    logic [4:0] sub;
    logic       known;
    logic       go;
    logic       carry0;
    assign sub = issue.instruction[10:6];
    assign known = issue.instruction[31:26] == EXTENSION_MAJOR_OPCODE && !sub[4]
        && issue.instruction[5:0] inside {FUNC_NARROW, FUNC_WIDE} && sub[1:0] == 2'h0;
    assign go = issue.valid && known && issue.extension_enabled;
    assign carry0 = 9'(issue.source_a[7:0]) + 9'(issue.source_b[7:0]) > 9'h0FF;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_retire_follows: assert property (issue.valid |=> retire.valid)
        else $error("retire missing");
    a_retire_quiet: assert property (!issue.valid |=> !retire.valid)
        else $error("stray retire");
    a_dest_field: assert property (
        issue.valid |=> retire.dest == $past(issue.instruction[15:11]))
        else $error("dest wrong");
    a_reserved_op: assert property (
        issue.valid && !known |=> retire.reserved_fault && !retire.disabled_fault)
        else $error("reserved missed");
    a_disabled_op: assert property (
        issue.valid && known && !issue.extension_enabled
        |=> retire.disabled_fault && retire.data == 64'h0)
        else $error("disabled missed");
    a_wrap_byte: assert property (
        go && sub == SUBOP_BYTE_WRAP
        |=> retire.data[7:0] == 8'($past(issue.source_a[7:0]) + $past(issue.source_b[7:0])))
        else $error("wrap byte wrong");
    a_sat_byte: assert property (go && sub == SUBOP_BYTE_SAT && carry0 |=> retire.data[7:0] == 8'hFF)
        else $error("sat byte wrong");
    a_flag_set: assert property (go && !sub[3] && carry0 |=> dsp_control_state[OVERFLOW_BIT])
        else $error("flag not set");
    a_flag_sticky: assert property (
        dsp_control_state[OVERFLOW_BIT] && !ctrl_write |=> dsp_control_state[OVERFLOW_BIT])
        else $error("flag cleared");
    a_other_bits: assert property (
        !ctrl_write |=> dsp_control_state[19:0] == $past(dsp_control_state[19:0])
        && dsp_control_state[31:21] == $past(dsp_control_state[31:21]))
        else $error("control changed");
    a_narrow_fill: assert property (
        go && issue.instruction[5:0] == FUNC_NARROW |=> retire.data[63:32] == {32{retire.data[31]}})
        else $error("upper fill wrong");
endmodule : simd_add_asserts

bind unsigned_simd_add_unit simd_add_asserts u_asserts (.clock(clock), .rst_n(rst_n),
    .issue(issue), .ctrl_write(ctrl_write), .ctrl_write_data(ctrl_write_data),
    .retire(retire), .dsp_control_state(dsp_control_state));

//--- tb/regfile_model.sv
module regfile_model
    import simd_add_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Retire from unit
    input  wire retire_type retire,
    // Last value written back
    output logic [63:0]     wb_data_q
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wb_data_q <= 64'h0;
        end else if (retire.valid && !retire.reserved_fault && !retire.disabled_fault) begin
            wb_data_q <= retire.data;
        end
    end
endmodule : regfile_model

//--- tb/test_unsigned_simd_add_unit.sv
module test_unsigned_simd_add_unit
    import simd_add_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock;
    logic        rst_n;
    logic        ctrl_write;
    logic [31:0] ctrl_write_data;
    logic [31:0] dsp_control_state;
    logic [31:0] ctrl_model;
    logic [63:0] wb_data_q;
    issue_type   issue;
    retire_type  retire;
    int          miscompares;
    int          checked;

    unsigned_simd_add_unit uut (.clock(clock), .rst_n(rst_n), .issue(issue),
        .ctrl_write(ctrl_write), .ctrl_write_data(ctrl_write_data), .retire(retire),
        .dsp_control_state(dsp_control_state));
    regfile_model partner (.clock(clock), .rst_n(rst_n), .retire(retire), .wb_data_q(wb_data_q));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic check(input string name, input logic [63:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [63:0] model(input logic [5:0] fn, input logic [4:0] so,
                                          input logic [63:0] a, b, output logic ovf);
        int w;
        logic [63:0] m, x, r;
        w = so[3] ? 16 : 8;
        m = (64'h1 << w) - 1;
        r = 64'h0;
        ovf = 1'b0;
        for (int i = 0; i < (fn == FUNC_WIDE ? 64 : 32) / w; i++) begin
            x = ((a >> (i * w)) & m) + ((b >> (i * w)) & m);
            ovf |= x > m;
            x = (x > m && so[2]) ? m : x & m;
            r |= x << (i * w);
        end
        if (fn == FUNC_NARROW) r[63:32] = {32{r[31]}};
        return r;
    endfunction : model

    task automatic run_op(input logic [5:0] op, fn, input logic [4:0] so,
                          input logic [63:0] a, b, input logic en, wr, input logic [31:0] wd);
        logic [63:0] r;
        logic ovf, res, dis;
        r = model(fn, so, a, b, ovf);
        res = op != EXTENSION_MAJOR_OPCODE || !(fn inside {FUNC_NARROW, FUNC_WIDE})
            || !(so inside {SUBOP_BYTE_WRAP, SUBOP_BYTE_SAT, SUBOP_HALF_WRAP, SUBOP_HALF_SAT});
        dis = !res && !en;
        if (res || dis) r = 64'h0;
        ctrl_model = (wr ? wd : ctrl_model) | (32'(ovf && !res && !dis) << OVERFLOW_BIT);
        issue = '{1'b1, {op, 5'h03, 5'h07, a[4:0], so, fn}, a, b, en};
        ctrl_write = wr;
        ctrl_write_data = wd;
        @(negedge clock);
        issue.valid = 1'b0;
        ctrl_write = 1'b0;
        check("valid", 64'(retire.valid), 64'h1);
        check("dest", 64'(retire.dest), 64'(a[4:0]));
        check("data", retire.data, r);
        check("reserved", 64'(retire.reserved_fault), 64'(res));
        check("disabled", 64'(retire.disabled_fault), 64'(dis));
        check("control", 64'(dsp_control_state), 64'(ctrl_model));
        @(negedge clock);
        check("idle", 64'(retire.valid), 64'h0);
        if (!res && !dis) check("write back", wb_data_q, r);
    endtask : run_op

    task automatic t_all_forms;
        logic [5:0] fns [2] = '{FUNC_NARROW, FUNC_WIDE};
        logic [4:0] sos [4] = '{SUBOP_BYTE_WRAP, SUBOP_BYTE_SAT, SUBOP_HALF_WRAP, SUBOP_HALF_SAT};
        foreach (fns[f]) begin
            foreach (sos[s]) begin
                run_op(EXTENSION_MAJOR_OPCODE, fns[f], sos[s], 64'hFF80_7F01_FFF0_8001,
                       64'h0180_0180_0020_8000, 1'b1, 1'b1, 32'h0);
                run_op(EXTENSION_MAJOR_OPCODE, fns[f], sos[s], 64'h00FF_7FFF_00FF_1234,
                       64'h0001_0001_0001_0101, 1'b1, 1'b1, 32'h0);
            end
        end
    endtask : t_all_forms

    task automatic t_sticky;
        run_op(EXTENSION_MAJOR_OPCODE, FUNC_WIDE, SUBOP_HALF_WRAP, 64'h1, 64'h1, 1, 1, 32'hA5A5_0F0F);
        run_op(EXTENSION_MAJOR_OPCODE, FUNC_WIDE, SUBOP_HALF_SAT, 64'hFFFF, 64'h1, 1, 0, 32'h0);
        run_op(EXTENSION_MAJOR_OPCODE, FUNC_NARROW, SUBOP_BYTE_WRAP, 64'h1, 64'h1, 1, 0, 32'h0);
        run_op(EXTENSION_MAJOR_OPCODE, FUNC_NARROW, SUBOP_BYTE_WRAP, 64'h1, 64'h1, 1, 1, 32'h0);
    endtask : t_sticky

    task automatic t_faults;
        run_op(6'h1E, FUNC_WIDE, SUBOP_BYTE_SAT, 64'hFF, 64'hFF, 1, 0, 32'h0);
        run_op(EXTENSION_MAJOR_OPCODE, 6'h11, SUBOP_BYTE_SAT, 64'hFF, 64'hFF, 1, 0, 32'h0);
        run_op(EXTENSION_MAJOR_OPCODE, FUNC_NARROW, 5'h01, 64'hFF, 64'hFF, 1, 0, 32'h0);
        run_op(EXTENSION_MAJOR_OPCODE, FUNC_WIDE, SUBOP_BYTE_SAT, 64'hFF, 64'hFF, 0, 0, 32'h0);
        run_op(6'h00, FUNC_WIDE, SUBOP_BYTE_SAT, 64'hFF, 64'hFF, 0, 0, 32'h0);
    endtask : t_faults

    task automatic t_reset;
        run_op(EXTENSION_MAJOR_OPCODE, FUNC_NARROW, SUBOP_HALF_SAT, 64'hFFFF, 64'h1, 1, 1,
               32'h0000_F00F);
        issue.valid = 1'b1;
        rst_n = 1'b0;
        @(negedge clock);
        check("reset valid", 64'(retire.valid), 64'h0);
        check("reset data", retire.data, 64'h0);
        check("reset control", 64'(dsp_control_state), 64'(CTRL_RESET));
        rst_n = 1'b1;
        ctrl_model = CTRL_RESET;
        run_op(EXTENSION_MAJOR_OPCODE, FUNC_WIDE, SUBOP_BYTE_WRAP, 64'hFF00, 64'h0100, 1, 0,
               32'h0);
    endtask : t_reset

    task automatic wrap_up;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        rst_n = 1'b0;
        ctrl_write = 1'b0;
        ctrl_write_data = 32'h0;
        issue = '0;
        ctrl_model = 32'h0;
        miscompares = 0;
        checked = 0;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        t_all_forms();
        t_sticky();
        t_faults();
        t_reset();
        wrap_up();
    end
endmodule : test_unsigned_simd_add_unit
